// [shared/vic_pkg.sv]
// ==========================================================
// shared constants for the vectored interrupt controller
// ==========================================================
package vic_pkg;

  // source indices; the three vectored ones first, in priority order
  localparam int NSRC     = 4;
  localparam int NVEC     = 3;
  localparam int SRC_TICK = 0;
  localparam int SRC_EXT  = 1;
  localparam int SRC_SER  = 2;
  localparam int SRC_TEST = 3;

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_REQ      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_REQ_SET  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_REQ_CLR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REQ_TCLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ENA      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ENA_SET  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ENA_CLR  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STAT     = 8'h24;

  // reset values
  localparam logic [NSRC-1:0] FLAGS_RST = 4'h0;
  localparam logic [3:0]      MODE_RST  = 4'h0;

  // mode nibble: bits 1:0 edge, bits 3:2 sampling clock
  localparam int MODE_EDGE_LO = 0;
  localparam int MODE_SCLK_LO = 2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  localparam logic [1:0] SCLK_A    = 2'h0;
  localparam logic [1:0] SCLK_B    = 2'h1;
  localparam logic [1:0] SCLK_C    = 2'h2;
  localparam int SCLK_DIV_B = 16;
  localparam int SCLK_DIV_C = 64;
  localparam int PRE_W      = 6;

  // control and status bit positions
  localparam int CTRL_IME = 0;
  localparam int STAT_IST = 0;
  localparam int STAT_PIN = 1;
  localparam int STAT_SVC = 2;

  // timing
  localparam int CLK_NS = 50;
  localparam int SVC_MC = 3;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // vector table: entry n sits at program address 2n
  localparam int VEC_W = 12;
  localparam logic [2:0] VENT_TICK = 3'h1;
  localparam logic [2:0] VENT_EXT  = 3'h2;
  localparam logic [2:0] VENT_SER  = 3'h4;

  typedef enum logic {VIC_IDLE, VIC_SVC} vic_state_t;

endpackage : vic_pkg

// [verilog/vic_pin_edge.sv]
`timescale 1ns/100ps
// ==========================================================
// testable input: synchroniser and rising edge detect
// ==========================================================
module vic_pin_edge import vic_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      rise
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // no sampled filter here; narrow pulses are the driver's problem
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      rise      <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      rise      <= sync2_reg & ~prev_reg;
    end
  end
endmodule : vic_pin_edge

// [verilog/vic_noise_filter.sv]
`timescale 1ns/100ps
// ==========================================================
// external edge input: sampled noise filter
// ==========================================================
module vic_noise_filter import vic_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       pin,
  input  wire logic [1:0] sclk_sel,
  output logic            level,
  output logic            rise,
  output logic            fall
);
  logic [PRE_W-1:0] pre_reg;
  logic             sync1_reg;
  logic             sync2_reg;
  logic             samp_reg;
  logic             tick;

  // sampling strobe for the selected clock; code 3 acts as the slowest
  function automatic logic samp_tick(input logic [1:0] sel,
                                     input logic [PRE_W-1:0] cnt);
    logic t;
    t = 1'b0;
    unique case (sel)
      SCLK_A:  t = 1'b1;
      SCLK_B:  t = ((32'(cnt) % SCLK_DIV_B) == 0);
      default: t = ((32'(cnt) % SCLK_DIV_C) == 0);
    endcase
    return t;
  endfunction : samp_tick

  assign tick = samp_tick(sclk_sel, pre_reg);

  // free running prescaler
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pre_reg <= '0;
    else         pre_reg <= pre_reg + 1'b1;
  end

  // a level is taken only once two samples in a row agree
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      samp_reg  <= 1'b0;
      level     <= 1'b0;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      rise      <= 1'b0;
      fall      <= 1'b0;
      if (tick) begin
        samp_reg <= sync2_reg;
        if (sync2_reg == samp_reg && sync2_reg != level) begin
          level <= sync2_reg;
          rise  <= sync2_reg;
          fall  <= ~sync2_reg;
        end
      end
    end
  end
endmodule : vic_noise_filter

// [verilog/vic_ctrl.sv]
`timescale 1ns/100ps
// Contract
// - three vectored sources plus one testable input that never vectors
// - fixed priority: timer tick, then external edge, then serial done
// - vectors at 0002H tick, 0004H external edge, 0008H serial done
// - vector for entry n is read from program address 2n
// - testable input has an enable but never raises a vectored request
// - flags set by their event, cleared automatically when serviced
// - enable flag 1 permits its interrupt, 0 blocks it
// - vectored request whenever request flag and enable flag are both set
// - vectored requests release halt, except the external edge one
// - flags accessible per bit and as nibbles; atomic test-and-clear
// - flag set by software vectors exactly like a hardware event
// - reset clears every request and enable flag
// - external flag on selected edge; testable flag on rising edge only
// - external filter accepts a level after two equal samples
// - filter sampling clock chosen from three in the mode register
// - external pin read as port also goes through the filter
// - testable input has no sampled filter; driver supplies wide pulses
// - reset clears mode register, selecting rising edge
// - mode register written only as a whole nibble
// - acknowledge needs global enable and the source enable
// - reset clears global enable
// - acknowledge saves in-service bit then sets it; return restores
// - servicing takes three machine cycles before the routine starts
// - requests held pending while globally disabled
module vic_ctrl import vic_pkg::*; #(
  parameter int MC_CLKS = 1
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              interval_tick_source,
  input  wire logic              serial_done_source,
  input  wire logic              ext_edge_source,
  input  wire logic              test_input_source,
  input  wire logic              cpu_ack,
  input  wire logic              irq_return_op,
  output logic                   irq_req,
  output logic [VEC_W-1:0]       irq_vector,
  output logic                   svc_start,
  output logic                   halt_release,
  output logic                   ext_port_level
);
  localparam int SVC_CLKS = SVC_MC * MC_CLKS;
  localparam int CNT_W    = $clog2(SVC_CLKS + 1);

  // ==========================================================
  // state
  // ==========================================================
  logic [NSRC-1:0]  source_request_flag;
  logic [NSRC-1:0]  source_enable_flag;
  logic [NSRC-1:0]  req_next;
  logic [NSRC-1:0]  ena_next;
  logic [3:0]       edge_mode_register;
  logic             global_irq_enable;
  logic             in_service_status;
  logic             ist_saved_reg;
  vic_state_t       state_reg;
  logic [CNT_W-1:0] svc_cnt_reg;
  logic [1:0]       win_reg;
  logic [NVEC-1:0]  vectored_request;
  logic             any_vreq;
  logic [1:0]       win_idx;
  logic             ack_take;
  logic             ext_rise;
  logic             ext_fall;
  logic             ext_hit;
  logic             test_rise;
  logic [NSRC-1:0]  hw_set;

  // ==========================================================
  // helpers
  // ==========================================================
  // lowest index wins, so the tick beats the edge beats serial
  function automatic logic [1:0] prio(input logic [NVEC-1:0] v);
    logic [1:0] r;
    r = 2'(SRC_SER);
    if (v[SRC_EXT])  r = 2'(SRC_EXT);
    if (v[SRC_TICK]) r = 2'(SRC_TICK);
    return r;
  endfunction : prio

  // table entry number, then program address 2n
  function automatic logic [VEC_W-1:0] vec_of(input logic [1:0] idx);
    logic [2:0] n;
    n = VENT_SER;
    if (idx == 2'(SRC_EXT))  n = VENT_EXT;
    if (idx == 2'(SRC_TICK)) n = VENT_TICK;
    return {{(VEC_W-4){1'b0}}, n, 1'b0};
  endfunction : vec_of

  // ==========================================================
  // pin conditioning
  // ==========================================================
  vic_noise_filter u_filt (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pin      (ext_edge_source),
    .sclk_sel (edge_mode_register[MODE_SCLK_LO +: 2]),
    .level    (ext_port_level),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );

  vic_pin_edge u_test (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (test_input_source),
    .rise    (test_rise)
  );

  // edge selection for the external source
  always_comb begin
    unique case (edge_mode_register[MODE_EDGE_LO +: 2])
      EDGE_RISE: ext_hit = ext_rise;
      EDGE_FALL: ext_hit = ext_fall;
      EDGE_BOTH: ext_hit = ext_rise | ext_fall;
      EDGE_NONE: ext_hit = 1'b0;
    endcase
  end

  always_comb begin
    hw_set           = '0;
    hw_set[SRC_TICK] = interval_tick_source;
    hw_set[SRC_EXT]  = ext_hit;
    hw_set[SRC_SER]  = serial_done_source;
    hw_set[SRC_TEST] = test_rise;
  end

  // ==========================================================
  // request logic
  // ==========================================================
  // testable bit left out on purpose: it only ever sets a flag
  assign vectored_request = source_request_flag[NVEC-1:0]
                          & source_enable_flag[NVEC-1:0];
  assign any_vreq = |vectored_request;
  assign win_idx  = prio(vectored_request);
  // flags stay untouched while masked, so they remain pending
  assign ack_take = cpu_ack & irq_req & any_vreq
                  & (state_reg == VIC_IDLE);

  // ==========================================================
  // bus slave
  // ==========================================================
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic              wlow_reg;
  logic              wr_en;
  logic              wr_hit;
  logic              ar_hs;
  logic              rd_tclr;
  logic [31:0]       rd_mux;
  logic              rd_hit;

  assign wr_en   = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign ar_hs   = s_axi_arvalid & s_axi_arready;
  assign rd_tclr = ar_hs & (s_axi_araddr == OFF_REQ_TCLR);

  always_comb begin
    unique case (awaddr_reg)
      OFF_REQ, OFF_REQ_SET, OFF_REQ_CLR, OFF_ENA, OFF_ENA_SET,
      OFF_ENA_CLR, OFF_MODE, OFF_CTRL: wr_hit = 1'b1;
      default:                         wr_hit = 1'b0;
    endcase
  end

  // address and data taken in either order, answer after both
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wlow_reg      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_full_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wlow_reg     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (!w_full_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_en) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFF_REQ, OFF_REQ_TCLR: rd_mux[NSRC-1:0] = source_request_flag;
      OFF_ENA:               rd_mux[NSRC-1:0] = source_enable_flag;
      OFF_MODE:              rd_mux[3:0]      = edge_mode_register;
      OFF_CTRL:              rd_mux[CTRL_IME] = global_irq_enable;
      OFF_STAT: begin
        rd_mux[STAT_IST] = in_service_status;
        rd_mux[STAT_PIN] = ext_port_level;
        rd_mux[STAT_SVC] = (state_reg == VIC_SVC);
      end
      OFF_REQ_SET, OFF_REQ_CLR, OFF_ENA_SET, OFF_ENA_CLR: ;
      default: rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // flags
  // ==========================================================
  // set beats clear everywhere, so no event is lost to a clear
  always_comb begin
    logic [NSRC-1:0] set_v;
    logic [NSRC-1:0] clr_v;
    set_v = hw_set;
    clr_v = '0;
    if (ack_take) clr_v[win_idx] = 1'b1;
    if (rd_tclr)  clr_v = clr_v | source_request_flag;
    if (wr_en && wlow_reg) begin
      unique case (awaddr_reg)
        OFF_REQ: begin
          clr_v = '1;
          set_v = set_v | wdata_reg[NSRC-1:0];
        end
        OFF_REQ_SET: set_v = set_v | wdata_reg[NSRC-1:0];
        OFF_REQ_CLR: clr_v = clr_v | wdata_reg[NSRC-1:0];
        default: ;
      endcase
    end
    req_next = (source_request_flag & ~clr_v) | set_v;
  end

  always_comb begin
    ena_next = source_enable_flag;
    if (wr_en && wlow_reg) begin
      unique case (awaddr_reg)
        OFF_ENA:     ena_next = wdata_reg[NSRC-1:0];
        OFF_ENA_SET: ena_next = ena_next | wdata_reg[NSRC-1:0];
        OFF_ENA_CLR: ena_next = ena_next & ~wdata_reg[NSRC-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      source_request_flag <= FLAGS_RST;
      source_enable_flag  <= FLAGS_RST;
    end else begin
      source_request_flag <= req_next;
      source_enable_flag  <= ena_next;
    end
  end

  // mode and global enable; mode only as a whole nibble
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_mode_register <= MODE_RST;
      global_irq_enable  <= 1'b0;
    end else if (wr_en && wlow_reg) begin
      if (awaddr_reg == OFF_MODE)
        edge_mode_register <= wdata_reg[3:0];
      if (awaddr_reg == OFF_CTRL)
        global_irq_enable <= wdata_reg[CTRL_IME];
    end
  end

  // ==========================================================
  // acknowledge sequence
  // ==========================================================
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= VIC_IDLE;
      svc_cnt_reg   <= '0;
      win_reg       <= '0;
      svc_start     <= 1'b0;
      in_service_status <= 1'b0;
      ist_saved_reg <= 1'b0;
    end else begin
      svc_start <= 1'b0;
      unique case (state_reg)
        VIC_IDLE: if (ack_take) begin
          state_reg         <= VIC_SVC;
          svc_cnt_reg       <= CNT_W'(SVC_CLKS - 1);
          win_reg           <= win_idx;
          ist_saved_reg     <= in_service_status;
          in_service_status <= 1'b1;
        end
        VIC_SVC: begin
          if (svc_cnt_reg == '0) begin
            state_reg <= VIC_IDLE;
            svc_start <= 1'b1;
          end else begin
            svc_cnt_reg <= svc_cnt_reg - 1'b1;
          end
        end
      endcase
      if (irq_return_op && !ack_take)
        in_service_status <= ist_saved_reg;
    end
  end

  // ==========================================================
  // outputs to the core
  // ==========================================================
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req      <= 1'b0;
      irq_vector   <= '0;
      halt_release <= 1'b0;
    end else begin
      irq_req <= global_irq_enable & ~in_service_status & any_vreq
               & (state_reg == VIC_IDLE) & ~ack_take;
      irq_vector <= (state_reg == VIC_SVC) ? vec_of(win_reg)
                                           : vec_of(win_idx);
      halt_release <= |(vectored_request
                        & ~(NVEC'(1) << SRC_EXT));
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_tick_first: assert property (
    ack_take && vectored_request[SRC_TICK]
    |-> ##[1:8] svc_start && irq_vector == 12'h002)
    else $error("tick not serviced first");
  a_ext_vector: assert property (
    ack_take && vectored_request == 3'h2
    |-> ##[1:8] svc_start && irq_vector == 12'h004)
    else $error("wrong external vector");
  // enabled testable flag alone must never reach the core
  a_test_novec: assert property (
    source_request_flag == 4'h8 && source_enable_flag[SRC_TEST]
    |=> !irq_req)
    else $error("testable input raised a request");
  a_ime_gate: assert property (!global_irq_enable |=> !irq_req)
    else $error("request while globally disabled");
  a_ist_set: assert property (
    ack_take |=> in_service_status ##1 !irq_req)
    else $error("in-service not set on acknowledge");
  // a fresh tick event in the ack cycle may legally re-set its flag
  a_only_winner: assert property (
    ack_take && vectored_request[SRC_SER]
    && vectored_request[SRC_TICK] && !wr_en && !rd_tclr
    |=> source_request_flag[SRC_SER]
        && (!source_request_flag[SRC_TICK] || $past(hw_set[SRC_TICK])))
    else $error("wrong flag cleared");
  a_halt_noext: assert property (
    vectored_request == 3'h2 |=> !halt_release)
    else $error("external edge released halt");
  a_svc_length: assert property (
    $rose(state_reg == VIC_SVC)
    |-> (state_reg == VIC_SVC)[*3] ##1 svc_start)
    else $error("service length wrong");

  c_tick_svc: cover property (ack_take && win_idx == 2'(SRC_TICK));
  c_ser_svc: cover property (ack_take && win_idx == 2'(SRC_SER));
  c_test_flag: cover property ($rose(source_request_flag[SRC_TEST]));
  c_tclr: cover property (rd_tclr && |source_request_flag);

endmodule : vic_ctrl

// [tb/vic_cpu_model.sv]
`timescale 1ns/100ps
// ======
// core model: takes vectors, returns at once
// ======
module vic_cpu_model import vic_pkg::*; (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             irq_req,
  input  wire logic [VEC_W-1:0] irq_vector,
  input  wire logic             svc_start,
  input  wire logic             stall,
  output logic                  cpu_ack,
  output logic                  irq_return_op,
  output logic [VEC_W-1:0]      last_vec,
  output int                    svc_cnt
);
  logic busy_reg;
  // stall holds the ack off, as a slow core would
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_ack       <= 1'h0;
      irq_return_op <= 1'h0;
      busy_reg      <= 1'h0;
      last_vec      <= '0;
      svc_cnt       <= 0;
    end else begin
      cpu_ack       <= irq_req && !busy_reg && !cpu_ack && !stall;
      irq_return_op <= svc_start;
      if (cpu_ack) busy_reg <= 1'h1;
      if (irq_return_op) busy_reg <= 1'h0;
      if (svc_start) begin
        last_vec <= irq_vector;
        svc_cnt  <= svc_cnt + 1;
      end
    end
  end
endmodule : vic_cpu_model

// [tb/tb_top.sv]
`timescale 1ns/100ps
// ======
// bench: bus tasks and interrupt scenarios
// ======
module tb_top import vic_pkg::*; ;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic interval_tick_source = 0, serial_done_source = 0, stall = 1;
  logic ext_edge_source = 0, test_input_source = 0, irq_req;
  logic cpu_ack, irq_return_op, svc_start, halt_release, ext_port_level;
  logic [VEC_W-1:0] irq_vector, last_vec;
  int svc_cnt, fail_count = 0, compares = 0;
  logic [ADDR_W-1:0] offs[4] = '{OFF_REQ, OFF_ENA, OFF_MODE, OFF_CTRL};
  always #25 sys_clk = ~sys_clk;
  vic_ctrl i_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .interval_tick_source,
    .serial_done_source, .ext_edge_source, .test_input_source, .cpu_ack,
    .irq_return_op, .irq_req, .irq_vector, .svc_start, .halt_release,
    .ext_port_level);
  vic_cpu_model i_cpu (.sys_clk, .sys_rst, .irq_req, .irq_vector,
    .svc_start, .stall, .cpu_ack, .irq_return_op, .last_vec, .svc_cnt);
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bounded edge; a hang ends the run as a mismatch
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 300) begin
      fail_count++;
      end_of_test;
    end
  endtask : tick
  task automatic wr(logic [7:0] a, logic [31:0] v);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic rchk(logic [7:0] a, logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  task automatic wsvc(int k);
    int n = 0;
    while (svc_cnt < k) tick(n);
  endtask : wsvc
  // ======
  // main sequence
  // ======
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    foreach (offs[i]) rchk(offs[i], 32'h0);
    rd(8'h40);
    chk("rresp", RESP_SLVERR, r);
    wr(8'h40, 32'h1);
    chk("bresp", RESP_SLVERR, r);
    // three software flags while the core stalls
    wr(OFF_ENA, 32'h7);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_REQ_SET, 32'h7);
    repeat (3) @(posedge sys_clk);
    chk("halt", 32'h1, halt_release);
    chk("irq_req", 32'h1, irq_req);
    stall <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      wsvc(i + 1);
      chk("vector", 32'h2 << i, last_vec);
    end
    rchk(OFF_REQ, 32'h0);
    // hardware events held pending while globally disabled
    wr(OFF_CTRL, 32'h0);
    interval_tick_source <= 1'h1;
    serial_done_source   <= 1'h1;
    @(posedge sys_clk);
    interval_tick_source <= 1'h0;
    serial_done_source   <= 1'h0;
    rchk(OFF_REQ, 32'h5);
    chk("irq_req", 32'h0, irq_req);
    wr(OFF_CTRL, 32'h1);
    wsvc(5);
    chk("vector", 32'h8, last_vec);
    // testable input flags but never vectors
    wr(OFF_ENA, 32'h8);
    test_input_source <= 1'h1;
    repeat (12) @(posedge sys_clk);
    rchk(OFF_REQ, 32'h8);
    chk("irq_req", 32'h0, irq_req);
    rchk(OFF_REQ_TCLR, 32'h8);
    rchk(OFF_REQ, 32'h0);
    // external pin: disable, set mode, clear, then enable
    wr(OFF_CTRL, 32'h0);
    for (int i = 2; i >= 0; i--) begin
      wr(OFF_MODE, 32'(i * 4 + 1));
      rchk(OFF_MODE, 32'(i * 4 + 1));
    end
    wr(OFF_ENA, 32'h2);
    ext_edge_source <= 1'h1;
    repeat (12) @(posedge sys_clk);
    wr(OFF_REQ_CLR, 32'hF);
    chk("port", 32'h1, ext_port_level);
    ext_edge_source <= 1'h0;
    @(posedge sys_clk);
    ext_edge_source <= 1'h1;
    repeat (12) @(posedge sys_clk);
    rchk(OFF_REQ, 32'h0);
    ext_edge_source <= 1'h0;
    repeat (12) @(posedge sys_clk);
    rchk(OFF_REQ, 32'h2);
    stall <= 1'h1;
    wr(OFF_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk("halt", 32'h0, halt_release);
    stall <= 1'h0;
    wsvc(6);
    chk("vector", 32'h4, last_vec);
    end_of_test;
  end
endmodule : tb_top
